/* File: verilog/phy_regs_pkg.sv */
// package: offsets, fields and reset values of the identifier/advert regs
package phy_regs_pkg;
	// register offsets (word index; byte address is four times this)
	localparam logic [4:0]  IDX_ID_HIGH      = 5'h02;
	localparam logic [4:0]  IDX_ID_LOW       = 5'h03;
	localparam logic [4:0]  IDX_ADVERT       = 5'h04;
	localparam logic [4:0]  IDX_CONTROL      = 5'h00;
	// control register field
	localparam int          CTRL_RESTART_BIT = 9;
	// identifier low field positions
	localparam int          OUI_LSB          = 10;
	localparam int          MODEL_LSB        = 4;
	localparam int          REV_LSB          = 0;
	// advertisement field positions
	localparam int          ADV_NEXT_PAGE_BIT = 15;
	localparam int          ADV_FAULT_BIT    = 13;
	localparam int          ADV_ABIL_LSB     = 5;
	localparam int          ADV_ABIL_W       = 4;
	localparam int          ADV_SEL_LSB      = 0;
	// reset and fixed values
	localparam logic [15:0] ADVERT_RESET     = 16'h01e1;
	localparam logic [3:0]  ABIL_RESET       = 4'hf;
	localparam logic [4:0]  SELECTOR_VALUE   = 5'h01;
	localparam logic        NEXT_PAGE_RESET  = 1'b0;
endpackage

/* File: verilog/advert_latch.sv */
// advertisement shadow: staged write value applied on negotiation restart
`timescale 1ns/1ps
module advert_latch
#(
	parameter int W = 5
)
(
	input  wire logic         i_clk,
	input  wire logic         i_reset_n,
	input  wire logic         i_restart,
	input  wire logic [W-1:0] i_staged,
	input  wire logic [W-1:0] i_reset_value,
	output logic      [W-1:0] o_active
);
	// active value follows the staged one only on restart
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			o_active <= i_reset_value;
		else if (i_restart)
			o_active <= i_staged; // [R4]
	end
endmodule

/* File: verilog/phy_id_adv_regs.sv */
// identifier low and autonegotiation advertisement registers on apb
// Function
// R1 - identifier is high register then low register
// R2 - low id read-only: oui, model, revision
// R3 - ability bits 8:5 writable by software
// R4 - writes apply only on negotiation restart
// R5 - advert at 0x04, resets to 0x01e1
// R6 - bit 15 next-page flag read-only zero
// R7 - remote-fault bit signalled to link partner
// R8 - ability bits map 100tx-fd down to 10t-hd
// R9 - selector bits 4:0 read-only 0x01
// R10 - reserved bits read zero, ignore writes
`timescale 1ns/1ps
module phy_id_adv_regs
#(
	parameter logic [15:0] ID_HIGH_VALUE = 16'h0123, // arbitrary value
	parameter logic [5:0]  OUI_LOW       = 6'h2a,    // arbitrary value
	parameter logic [5:0]  MODEL_NUMBER  = 6'h11,    // arbitrary value
	parameter logic [3:0]  REVISION      = 4'h3      // arbitrary value
)
(
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [31:0] o_phy_identifier,
	output logic             o_restart_autoneg,
	output logic             o_remote_fault_advertise,
	output logic             o_ability_100tx_full,
	output logic             o_ability_100tx_half,
	output logic             o_ability_10t_full,
	output logic             o_ability_10t_half,
	output logic             o_next_page_capable,
	output logic      [4:0]  o_selector
);
	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic        access;
	logic        aligned;
	logic [4:0]  word_idx;
	logic        hit_adv;
	logic        hit_ctrl;
	logic        mapped;
	logic [15:0] id_low;
	logic [15:0] advert;
	logic [3:0]  abil_staged;
	logic        fault_staged;
	logic [4:0]  active;
	logic        restart_req;

	// single-cycle access phase; unmapped or misaligned gives slverr
	assign access   = psel && penable;
	assign aligned  = (paddr[1:0] == 2'b00) && (paddr[7] == 1'b0);
	assign word_idx = paddr[6:2];
	assign hit_adv  = aligned && (word_idx == phy_regs_pkg::IDX_ADVERT);
	assign hit_ctrl = aligned && (word_idx == phy_regs_pkg::IDX_CONTROL);
	assign mapped   = hit_adv || hit_ctrl || (aligned &&
		(word_idx == phy_regs_pkg::IDX_ID_LOW ||
		 word_idx == phy_regs_pkg::IDX_ID_HIGH));
	assign pready   = 1'b1;
	assign pslverr  = access && !mapped;

	// ------------------------------------------------------------
	// identifier
	// ------------------------------------------------------------
	// constant fields; no write path exists at all
	assign id_low = {OUI_LOW, MODEL_NUMBER, REVISION}; // [R2]
	// high half first, low half last
	assign o_phy_identifier = {ID_HIGH_VALUE, id_low}; // [R1]

	// ------------------------------------------------------------
	// advertisement register
	// ------------------------------------------------------------
	// only fault and abilities are storage; reserved bits never stored
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			abil_staged  <= phy_regs_pkg::ABIL_RESET; // [R5]
			fault_staged <= 1'b0;
		end
		else if (access && pwrite && hit_adv)
		begin
			abil_staged  <= pwdata[phy_regs_pkg::ADV_ABIL_LSB +:
				phy_regs_pkg::ADV_ABIL_W]; // [R3]
			fault_staged <= pwdata[phy_regs_pkg::ADV_FAULT_BIT]; // [R7]
		end
	end

	// readback: next page fixed 0, reserved 0, selector fixed
	assign advert = {phy_regs_pkg::NEXT_PAGE_RESET, 1'b0, fault_staged,
		4'h0, abil_staged,
		phy_regs_pkg::SELECTOR_VALUE}; // [R6] [R9] [R10]

	// restart bit self-clears; one-cycle pulse to negotiation
	assign restart_req = access && pwrite && hit_ctrl &&
		pwdata[phy_regs_pkg::CTRL_RESTART_BIT];
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			o_restart_autoneg <= 1'b0;
		else
			o_restart_autoneg <= restart_req; // [R4]
	end

	// negotiated values held apart from the register copy
	advert_latch #(.W(5)) u_latch
	(
		.i_clk        (i_clk),
		.i_reset_n    (i_reset_n),
		.i_restart    (restart_req),
		.i_staged     ({fault_staged, abil_staged}),
		.i_reset_value({1'b0, phy_regs_pkg::ABIL_RESET}),
		.o_active     (active)
	);

	// ability order 8..5 = 100tx fd, 100tx hd, 10t fd, 10t hd
	assign o_ability_100tx_full     = active[3]; // [R8]
	assign o_ability_100tx_half     = active[2]; // [R8]
	assign o_ability_10t_full       = active[1]; // [R8]
	assign o_ability_10t_half       = active[0]; // [R8]
	assign o_remote_fault_advertise = active[4]; // [R7]
	assign o_next_page_capable      = phy_regs_pkg::NEXT_PAGE_RESET; // [R6]
	assign o_selector               = phy_regs_pkg::SELECTOR_VALUE; // [R9]

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	// registered read data, taken at setup so valid in access phase
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			if (aligned && word_idx == phy_regs_pkg::IDX_ID_LOW)
				prdata <= {16'h0000, id_low};
			else if (aligned && word_idx == phy_regs_pkg::IDX_ID_HIGH)
				prdata <= {16'h0000, ID_HIGH_VALUE};
			else if (hit_adv)
				prdata <= {16'h0000, advert}; // [R10]
			else
				prdata <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_id_const;
		@(posedge i_clk) disable iff (!i_reset_n)
		o_phy_identifier[15:0] == {OUI_LOW, MODEL_NUMBER, REVISION};
	endproperty
	a_id_const: assert property (p_id_const) // [R2]
		else $error("identifier low changed");

	property p_write_no_effect;
		@(posedge i_clk) disable iff (!i_reset_n)
		!restart_req |=> $stable(active);
	endproperty
	a_write_no_effect: assert property (p_write_no_effect) // [R4]
		else $error("advert active changed without restart");

	property p_restart_apply;
		@(posedge i_clk) disable iff (!i_reset_n)
		restart_req |=> active == {$past(fault_staged), $past(abil_staged)};
	endproperty
	a_restart_apply: assert property (p_restart_apply) // [R4]
		else $error("restart did not apply staged value");

	property p_adv_write;
		@(posedge i_clk) disable iff (!i_reset_n)
		access && pwrite && hit_adv |=> advert[8:5] == $past(pwdata[8:5]);
	endproperty
	a_adv_write: assert property (p_adv_write) // [R3]
		else $error("ability bits not written");

	property p_reserved;
		@(posedge i_clk) disable iff (!i_reset_n)
		advert[15:14] == 2'b00 && advert[12:9] == 4'h0;
	endproperty
	a_reserved: assert property (p_reserved) // [R10]
		else $error("reserved or next page bit set");

	property p_selector;
		@(posedge i_clk) disable iff (!i_reset_n)
		advert[4:0] == 5'h01;
	endproperty
	a_selector: assert property (p_selector) // [R9]
		else $error("selector not fixed");

	property p_reset_value;
		@(posedge i_clk) !i_reset_n |=> advert == 16'h01e1;
	endproperty
	a_reset_value: assert property (p_reset_value) // [R5]
		else $error("advert reset value wrong");

	property p_fault_out;
		@(posedge i_clk) disable iff (!i_reset_n)
		restart_req ##1 !restart_req [*2]
			|-> o_remote_fault_advertise == $past(fault_staged, 3);
	endproperty
	a_fault_out: assert property (p_fault_out) // [R7]
		else $error("remote fault not signalled");

	// read path of the fixed identifier half, not just the constant
	property p_id_read;
		@(posedge i_clk) disable iff (!i_reset_n)
		psel && !penable && !pwrite && aligned &&
			word_idx == phy_regs_pkg::IDX_ID_LOW
			|=> prdata == {16'h0000, OUI_LOW, MODEL_NUMBER, REVISION};
	endproperty
	a_id_read: assert property (p_id_read) // [R2]
		else $error("identifier low read data wrong");

	// fixed bits as software sees them on the bus
	property p_adv_read;
		@(posedge i_clk) disable iff (!i_reset_n)
		psel && !penable && !pwrite && hit_adv
			|=> prdata[31:14] == 18'h00000 && prdata[12:9] == 4'h0 &&
			prdata[4:0] == phy_regs_pkg::SELECTOR_VALUE;
	endproperty
	a_adv_read: assert property (p_adv_read) // [R10]
		else $error("advert fixed bits wrong on read");

	// restart reaches negotiation as exactly one pulse
	property p_restart_pulse;
		@(posedge i_clk) disable iff (!i_reset_n)
		restart_req |=> o_restart_autoneg ##1 !o_restart_autoneg;
	endproperty
	a_restart_pulse: assert property (p_restart_pulse) // [R4]
		else $error("restart pulse not one cycle long");

	c_restart: cover property (@(posedge i_clk) restart_req);
	c_fault_restart: cover property (@(posedge i_clk)
		restart_req && fault_staged);
	c_adv_wr: cover property (@(posedge i_clk) access && pwrite && hit_adv);
	c_unmapped: cover property (@(posedge i_clk) pslverr);
endmodule

/* File: verification/link_partner_model.sv */
// link partner stand-in: latches the base page sent at each restart
`timescale 1ns/1ps
module link_partner_model
(
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_restart,
	input  wire logic [5:0]  i_bits,
	input  wire logic [4:0]  i_sel,
	output logic      [15:0] o_page
);
	// page only moves on a restart, never on a plain register write
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			o_page <= 16'h0000;
		else if (i_restart)
			o_page <= {i_bits[5], 1'b0, i_bits[4], 4'h0, i_bits[3:0], i_sel};
	end
endmodule

/* File: verification/phy_id_adv_regs_test.sv */
// random and corner tests of the identifier and advertisement registers
`timescale 1ns/1ps
module phy_id_adv_regs_test;
	localparam logic [15:0] HI  = 16'h0abc; // arbitrary value
	localparam logic [15:0] LO  = {6'h15, 6'h2c, 4'h9}; // arbitrary value
	logic        i_clk, i_reset_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, ident, r, d;
	logic        rst, fault, fd100, hd100, fd10, hd10, next_page, e;
	logic [4:0]  sel;
	logic [15:0] page, act;
	int          err_total, tests_run, seed, i, n;

	phy_id_adv_regs #(.ID_HIGH_VALUE(HI), .OUI_LOW(LO[15:10]),
		.MODEL_NUMBER(LO[9:4]), .REVISION(LO[3:0])) dut (.i_clk(i_clk),
		.i_reset_n(i_reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .o_phy_identifier(ident),
		.o_restart_autoneg(rst), .o_remote_fault_advertise(fault),
		.o_ability_100tx_full(fd100), .o_ability_100tx_half(hd100),
		.o_ability_10t_full(fd10), .o_ability_10t_half(hd10),
		.o_next_page_capable(next_page), .o_selector(sel));
	link_partner_model lp (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_restart(rst),
		.i_bits({next_page, fault, fd100, hd100, fd10, hd10}),
		.i_sel(sel), .o_page(page));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// readback: writable fault and abilities kept, selector forced to one
	function automatic logic [15:0] adv(input logic [31:0] v);
		return (v[15:0] & 16'h21e0) | 16'h0001;
	endfunction

	task automatic finish_test;
		if (err_total == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] x,
		input logic [31:0] g);
		tests_run++;
		if (g !== x)
		begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", s, x, g);
		end
	endtask

	// one apb transfer; the idle edge comes first so no signal is set twice
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge i_clk);
		penable <= 1'b1;
		n = 0;
		@(posedge i_clk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 50)
			begin
				err_total++;
				finish_test();
			end
			@(posedge i_clk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] x,
		input logic xe);
		apb(1'b0, a, 32'h0);
		chk("prdata", {16'h0000, x}, r);
		chk("pslverr", {31'h0, xe}, {31'h0, e});
	endtask

	// active outputs laid out like the register
	task automatic chk_out;
		chk("active", {16'h0000, act},
			{16'h0000, next_page, 1'b0, fault, 4'h0,
			fd100, hd100, fd10, hd10, sel});
	endtask

	// ----------------------------------------
	// clock, timeout, main sequence
	// ----------------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	// a hang counts as a failure
	initial
	begin
		#800000;
		err_total++;
		finish_test();
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		i_reset_n = 1'b0;
		seed = 73;
		act = 16'h01e1;
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1'b1;
		chk("ident", {HI, LO}, ident);
		chk_out();
		rd(8'h08, HI, 1'b0);
		rd(8'h0c, LO, 1'b0);
		rd(8'h10, 16'h01e1, 1'b0);
		apb(1'b1, 8'h0c, 32'hffffffff);
		rd(8'h0c, LO, 1'b0);
		rd(8'h40, 16'h0000, 1'b1);
		for (i = 0; i < 12; i++)
		begin
			d = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $random(seed);
			apb(1'b1, 8'h10, d);
			rd(8'h10, adv(d), 1'b0);
			chk_out();
			apb(1'b1, 8'h00, 32'h00000200);
			act = adv(d);
			for (n = 0; n < 4 && rst !== 1'b1; n++)
				@(negedge i_clk);
			chk("restart", 32'h1, {31'h0, rst});
			chk_out();
			@(negedge i_clk);
			chk("pulse", 32'h0, {31'h0, rst});
			chk("page", {16'h0000, act}, {16'h0000, page});
		end
		// control write without the restart bit must change nothing
		apb(1'b1, 8'h10, 32'h00002000);
		apb(1'b1, 8'h00, 32'hfffffdff);
		@(negedge i_clk);
		chk("no restart", 32'h0, {31'h0, rst});
		chk_out();
		// restart to a non-default page, then reset in mid-run
		apb(1'b1, 8'h00, 32'h00000200);
		act = 16'h2001;
		@(negedge i_clk);
		chk_out();
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_reset_n <= 1'b1;
		act = 16'h01e1;
		@(negedge i_clk);
		chk_out();
		rd(8'h10, 16'h01e1, 1'b0);
		finish_test();
	end
endmodule
